// *** hw/angmr_regs.sv ***
// Purpose: Management registers 6..10, 13 and 14 of one copper port
// Assumes: Single clock, plain register port, read data one cycle after strobe
// Notes:   Negotiation engine and clause-45 space sit outside
`include "angmr_defs.svh"
`default_nettype none
module angmr_regs (
   input  wire logic                  clk_sys,
   input  wire logic                  resetn,
   input  wire logic [4:0]            reg_addr,
   input  wire logic [15:0]           reg_wdata,
   input  wire logic                  reg_wr,
   input  wire logic                  reg_rd,
   output logic      [15:0]           reg_rdata,
   input  wire angmr_pkg::angmr_an_sts_t an_sts,
   input  wire logic [15:0]           lp_np_word,
   output logic      [15:0]           np_tx_word,
   output logic      [2:0]            test_mode,
   output logic                       test_mode_valid,
   output logic                       ms_manual,
   output logic                       ms_force_master,
   output logic                       port_multi,
   output logic                       adv_gig_fd,
   output logic                       adv_gig_hd,
   output logic      [4:0]            target_device_address,
   output logic                       mmd_addr_wr,
   output logic                       mmd_data_wr,
   output logic                       mmd_data_rd,
   output logic                       mmd_post_inc,
   output logic      [15:0]           mmd_wdata,
   input  wire logic [15:0]           mmd_rdata
);

   // ****************************************
   // Storage
   // ****************************************
   logic [15:0] nptx_reg;
   logic [15:0] gctl_reg;
   logic [15:0] iac_reg;
   logic [15:0] iad_reg;
   logic [15:0] rdata_reg;
   logic        pdf_reg;
   logic        pgrx_reg;
   logic        msf_reg;
   logic [7:0]  idle_cnt_reg;
   logic [7:0]  idle_cnt_next;

   // ****************************************
   // Decode
   // ****************************************
   wire         hit_exp   = (reg_addr == `ANGMR_OFS_EXP);
   wire         hit_nptx  = (reg_addr == `ANGMR_OFS_NPTX);
   wire         hit_nprx  = (reg_addr == `ANGMR_OFS_NPRX);
   wire         hit_gctl  = (reg_addr == `ANGMR_OFS_GCTL);
   wire         hit_gsts  = (reg_addr == `ANGMR_OFS_GSTS);
   wire         hit_iac   = (reg_addr == `ANGMR_OFS_IAC);
   wire         hit_iad   = (reg_addr == `ANGMR_OFS_IAD);
   wire         rd_exp    = reg_rd && hit_exp;
   wire         rd_gsts   = reg_rd && hit_gsts;
   wire angmr_pkg::angmr_fn_t fn = angmr_pkg::angmr_fn_t'(iac_reg[15:14]);
   wire         fn_addr   = (fn == angmr_pkg::ANGMR_FN_ADDR);

   // Register values as read
   wire [15:0]  exp_val = {11'h000,
                           pdf_reg,
                           an_sts.lp_np_able,
                           1'b1,
                           pgrx_reg,
                           an_sts.lp_an_able};
   wire [15:0]  nptx_val = {nptx_reg[15], 1'b0, nptx_reg[13:12],
                            ~an_sts.tx_toggle,
                            nptx_reg[10:0]};
   wire [15:0]  nprx_val = {lp_np_word[15:12],
                            ~lp_np_word[`ANGMR_NP_TOG],
                            lp_np_word[10:0]};
   wire [15:0]  gsts_val = {msf_reg,
                            an_sts.ms_master,
                            an_sts.local_rx_ok,
                            an_sts.remote_rx_ok,
                            an_sts.lp_gig_fd,
                            an_sts.lp_gig_hd,
                            2'h0, idle_cnt_reg};
   wire [15:0]  iad_val  = fn_addr ? iad_reg : mmd_rdata;

   // Read multiplexer; unmapped addresses read zero
   wire [15:0]  rd_mux = hit_exp  ? exp_val  :
                         hit_nptx ? nptx_val :
                         hit_nprx ? nprx_val :
                         hit_gctl ? gctl_reg :
                         hit_gsts ? gsts_val :
                         hit_iac  ? iac_reg  :
                         hit_iad  ? iad_val  : 16'h0000;

   // ****************************************
   // Writable registers
   // ****************************************
   // Next page transmit: bits 15, 13, 12 and code field writable
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         nptx_reg <= `ANGMR_RST_NPTX;
      end else if (reg_wr && hit_nptx) begin
         nptx_reg <= reg_wdata & 16'hB7FF;
      end
   end

   // Gigabit control, all bits writable
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         gctl_reg <= `ANGMR_RST_GCTL;
      end else if (reg_wr && hit_gctl) begin
         gctl_reg <= reg_wdata;
      end
   end

   // Indirect access control and address/data latch
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         iac_reg <= `ANGMR_RST_IAC;
         iad_reg <= `ANGMR_RST_IAD;
      end else begin
         if (reg_wr && hit_iac) begin
            iac_reg <= reg_wdata;
         end
         if (reg_wr && hit_iad) begin
            iad_reg <= reg_wdata;
         end
      end
   end

   // ****************************************
   // Latched status bits
   // ****************************************
   // High latches: set wins over the clear by read
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         pdf_reg <= 1'b0;
         msf_reg <= 1'b0;
      end else begin
         pdf_reg <= an_sts.pd_fault | (pdf_reg & ~rd_exp);
         msf_reg <= an_sts.ms_fault | (msf_reg & ~rd_gsts);
      end
   end

   // Page received: new page sets, read returns to current state
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         pgrx_reg <= 1'b0;
      end else begin
         pgrx_reg <= an_sts.page_rx | (pgrx_reg & ~rd_exp);
      end
   end

   // Idle error counter, saturating, cleared by read
   always_comb begin
      idle_cnt_next = idle_cnt_reg;
      if (rd_gsts) begin
         idle_cnt_next = an_sts.idle_err ? 8'h01 : 8'h00;
      end else if (an_sts.idle_err && idle_cnt_reg != 8'hFF) begin
         idle_cnt_next = idle_cnt_reg + 8'h01;
      end
   end

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         idle_cnt_reg <= 8'h00;
      end else begin
         idle_cnt_reg <= idle_cnt_next;
      end
   end

   // ****************************************
   // Read data, one cycle after the strobe
   // ****************************************
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         rdata_reg <= 16'h0000;
      end else if (reg_rd) begin
         rdata_reg <= rd_mux;
      end else begin
         rdata_reg <= 16'h0000;
      end
   end

   // ****************************************
   // Outputs to the port logic
   // ****************************************
   assign reg_rdata             = rdata_reg;
   assign np_tx_word            = nptx_val;
   assign test_mode             = gctl_reg[15:13];
   assign test_mode_valid       = (gctl_reg[15:13] <= `ANGMR_TEST_LAST);
   assign ms_manual             = gctl_reg[`ANGMR_GC_MSEN];
   assign ms_force_master       = gctl_reg[`ANGMR_GC_MSEN] & gctl_reg[`ANGMR_GC_MSVAL];
   assign port_multi            = gctl_reg[10];
   assign adv_gig_fd            = gctl_reg[9];
   assign adv_gig_hd            = gctl_reg[8];
   assign target_device_address = iac_reg[4:0];
   assign mmd_addr_wr           = reg_wr && hit_iad && fn_addr;
   assign mmd_data_wr           = reg_wr && hit_iad && !fn_addr;
   assign mmd_data_rd           = reg_rd && hit_iad && !fn_addr;
   assign mmd_post_inc          = (fn == angmr_pkg::ANGMR_FN_INC_RW) ||
                                  ((fn == angmr_pkg::ANGMR_FN_INC_WR) && reg_wr);
   assign mmd_wdata             = reg_wdata;

   // ****************************************
   // Checks
   // ****************************************
   // Latched status bits: a new event wins over the clearing read
   AST_PDF_HOLD: assert property (@(posedge clk_sys) disable iff (!resetn)
      (pdf_reg && !rd_exp) |=> pdf_reg) else $error("fault bit lost");

   AST_PDF_SET: assert property (@(posedge clk_sys) disable iff (!resetn)
      an_sts.pd_fault |=> exp_val[`ANGMR_EXP_PDF]) else $error("fault not latched");

   AST_PDF_CLR: assert property (@(posedge clk_sys) disable iff (!resetn)
      (rd_exp && !an_sts.pd_fault) |=> !pdf_reg) else $error("fault bit not cleared by read");

   AST_PGRX_SET: assert property (@(posedge clk_sys) disable iff (!resetn)
      an_sts.page_rx |=> pgrx_reg) else $error("page flag missed");

   AST_PGRX_HOLD: assert property (@(posedge clk_sys) disable iff (!resetn)
      (pgrx_reg && !rd_exp) |=> pgrx_reg) else $error("page flag lost");

   AST_PGRX_CLR: assert property (@(posedge clk_sys) disable iff (!resetn)
      (rd_exp && !an_sts.page_rx) |=> !pgrx_reg) else $error("page flag not cleared by read");

   AST_MSF_HOLD: assert property (@(posedge clk_sys) disable iff (!resetn)
      (msf_reg && !rd_gsts) |=> msf_reg) else $error("ms fault lost");

   AST_MSF_SET: assert property (@(posedge clk_sys) disable iff (!resetn)
      an_sts.ms_fault |=> msf_reg) else $error("ms fault not latched");

   AST_MSF_CLR: assert property (@(posedge clk_sys) disable iff (!resetn)
      (rd_gsts && !an_sts.ms_fault) |=> !msf_reg) else $error("ms fault not cleared by read");

   // ****************************************
   // Page register checks
   // ****************************************
   // Fixed, read-only and writable bits of registers 6 to 8
   AST_LNP_ONE: assert property (@(posedge clk_sys) disable iff (!resetn)
      exp_val[`ANGMR_EXP_LNP]) else $error("local next page bit low");

   AST_LNP_RD: assert property (@(posedge clk_sys) disable iff (!resetn)
      (reg_rd && hit_exp) |=> reg_rdata[`ANGMR_EXP_LNP]) else $error("local next page read low");

   AST_EXP_LP: assert property (@(posedge clk_sys) disable iff (!resetn)
      (reg_rd && hit_exp) |=> (reg_rdata[`ANGMR_EXP_LPNP] == $past(an_sts.lp_np_able) &&
         reg_rdata[`ANGMR_EXP_LPAN] == $past(an_sts.lp_an_able))) else $error("partner ability wrong");

   AST_EXP_RSVD: assert property (@(posedge clk_sys) disable iff (!resetn)
      (reg_rd && hit_exp) |=> reg_rdata[15:5] == 11'h000) else $error("expansion reserved bits set");

   AST_TOG_INV: assert property (@(posedge clk_sys) disable iff (!resetn)
      np_tx_word[`ANGMR_NP_TOG] != an_sts.tx_toggle) else $error("tx toggle not inverted");

   AST_NPTX_TOGRD: assert property (@(posedge clk_sys) disable iff (!resetn)
      (reg_rd && hit_nptx) |=> reg_rdata[`ANGMR_NP_TOG] == ~$past(an_sts.tx_toggle)) else $error("tx toggle read wrong");

   AST_NPTX_WR: assert property (@(posedge clk_sys) disable iff (!resetn)
      (reg_wr && hit_nptx) |=> np_tx_word[10:0] == $past(reg_wdata[10:0])) else $error("code field not written");

   AST_NPTX_NEXT: assert property (@(posedge clk_sys) disable iff (!resetn)
      (reg_wr && hit_nptx) |=> np_tx_word[`ANGMR_NP_NEXT] == $past(reg_wdata[15])) else $error("next page not written");

   AST_NPTX_PAGE: assert property (@(posedge clk_sys) disable iff (!resetn)
      (reg_wr && hit_nptx) |=> np_tx_word[13:12] == $past(reg_wdata[13:12])) else $error("page bits not written");

   AST_NPTX_RSVD: assert property (@(posedge clk_sys) disable iff (!resetn)
      (reg_rd && hit_nptx) |=> !reg_rdata[`ANGMR_NP_ACK]) else $error("tx reserved bit set");

   AST_RX_TOG: assert property (@(posedge clk_sys) disable iff (!resetn)
      (reg_rd && hit_nprx) |=> reg_rdata[11] == ~$past(lp_np_word[11])) else $error("rx toggle wrong");

   AST_NPRX_RO: assert property (@(posedge clk_sys) disable iff (!resetn)
      (reg_rd && hit_nprx) |=> (reg_rdata[15:12] == $past(lp_np_word[15:12]) &&
         reg_rdata[10:0] == $past(lp_np_word[10:0]))) else $error("received page read wrong");

   // ****************************************
   // Control register checks
   // ****************************************
   // Control register and the outputs it drives
   AST_GCTL_WR: assert property (@(posedge clk_sys) disable iff (!resetn)
      (reg_wr && hit_gctl) |=> {test_mode, ms_manual, port_multi, adv_gig_fd, adv_gig_hd} ==
         {$past(reg_wdata[15:12]), $past(reg_wdata[10:8])}) else $error("control outputs not written");

   AST_TM_RSVD: assert property (@(posedge clk_sys) disable iff (!resetn)
      (test_mode > 3'h4) |-> !test_mode_valid) else $error("reserved test mode accepted");

   AST_TM_NORM: assert property (@(posedge clk_sys) disable iff (!resetn)
      (test_mode <= 3'h4) |-> test_mode_valid) else $error("defined test mode refused");

   AST_MS_GATE: assert property (@(posedge clk_sys) disable iff (!resetn)
      !ms_manual |-> !ms_force_master) else $error("manual value used while disabled");

   AST_MS_MASTER: assert property (@(posedge clk_sys) disable iff (!resetn)
      (ms_manual && gctl_reg[`ANGMR_GC_MSVAL]) |-> ms_force_master) else $error("manual master ignored");

   AST_MS_SLAVE: assert property (@(posedge clk_sys) disable iff (!resetn)
      (ms_manual && !gctl_reg[`ANGMR_GC_MSVAL]) |-> !ms_force_master) else $error("manual slave ignored");

   // ****************************************
   // Status register checks
   // ****************************************
   // Gigabit status reads and the idle error counter
   AST_GSTS_MSR: assert property (@(posedge clk_sys) disable iff (!resetn)
      (reg_rd && hit_gsts) |=> reg_rdata[`ANGMR_GS_MSR] == $past(an_sts.ms_master)) else $error("resolution bit wrong");

   AST_GSTS_RX: assert property (@(posedge clk_sys) disable iff (!resetn)
      (reg_rd && hit_gsts) |=> reg_rdata[13:12] ==
         {$past(an_sts.local_rx_ok), $past(an_sts.remote_rx_ok)}) else $error("receiver status wrong");

   AST_GSTS_LP: assert property (@(posedge clk_sys) disable iff (!resetn)
      (reg_rd && hit_gsts) |=> reg_rdata[11:10] ==
         {$past(an_sts.lp_gig_fd), $past(an_sts.lp_gig_hd)}) else $error("partner duplex wrong");

   AST_GSTS_RSVD: assert property (@(posedge clk_sys) disable iff (!resetn)
      (reg_rd && hit_gsts) |=> reg_rdata[9:8] == 2'h0) else $error("status reserved bits set");

   AST_IDLE_CLR: assert property (@(posedge clk_sys) disable iff (!resetn)
      (rd_gsts && !an_sts.idle_err) |=> idle_cnt_reg == 8'h00) else $error("idle count not cleared");

   AST_IDLE_SAT: assert property (@(posedge clk_sys) disable iff (!resetn)
      (idle_cnt_reg == 8'hFF && !rd_gsts) |=> idle_cnt_reg == 8'hFF) else $error("idle count wrapped");

   AST_IDLE_INC: assert property (@(posedge clk_sys) disable iff (!resetn)
      (an_sts.idle_err && !rd_gsts && idle_cnt_reg != 8'hFF) |=>
         idle_cnt_reg == $past(idle_cnt_reg) + 8'h01) else $error("idle error not counted");

   // ****************************************
   // Indirect access checks
   // ****************************************
   // Indirect access strobes and the address or data window
   AST_MMD_ADDR: assert property (@(posedge clk_sys) disable iff (!resetn)
      mmd_addr_wr |-> (fn == angmr_pkg::ANGMR_FN_ADDR && !mmd_data_wr)) else $error("address phase wrong");

   AST_FN_DATA_WR: assert property (@(posedge clk_sys) disable iff (!resetn)
      mmd_data_wr |-> (!fn_addr && !mmd_addr_wr)) else $error("data write in address phase");

   AST_FN_DATA_RD: assert property (@(posedge clk_sys) disable iff (!resetn)
      mmd_data_rd |-> !fn_addr) else $error("data read in address phase");

   AST_INC_RW: assert property (@(posedge clk_sys) disable iff (!resetn)
      (fn == angmr_pkg::ANGMR_FN_INC_RW) |-> mmd_post_inc) else $error("increment missing");

   AST_NO_INC: assert property (@(posedge clk_sys) disable iff (!resetn)
      (fn == angmr_pkg::ANGMR_FN_ADDR || fn == angmr_pkg::ANGMR_FN_DATA) |-> !mmd_post_inc) else $error("stray increment");

   AST_INC_WR: assert property (@(posedge clk_sys) disable iff (!resetn)
      (fn == angmr_pkg::ANGMR_FN_INC_WR) |-> (mmd_post_inc == reg_wr)) else $error("write-only increment wrong");

   AST_TARGET_DEVICE_ADDRESS_WR: assert property (@(posedge clk_sys) disable iff (!resetn)
      (reg_wr && hit_iac) |=> target_device_address == $past(reg_wdata[4:0])) else $error("device address not written");

   AST_IAD_ADDR: assert property (@(posedge clk_sys) disable iff (!resetn)
      (reg_rd && hit_iad && fn_addr) |=> reg_rdata == $past(iad_reg)) else $error("stored address not read");

   AST_IAD_DATA: assert property (@(posedge clk_sys) disable iff (!resetn)
      (reg_rd && hit_iad && !fn_addr) |=> reg_rdata == $past(mmd_rdata)) else $error("indirect data not read");

endmodule : angmr_regs
`default_nettype wire

// *** hw/angmr_defs.svh ***
// Purpose: Offsets, field positions, reset values for the gigabit management register group
// Assumes: Register index equals the printed management address
// Notes:   Definitions only
`ifndef ANGMR_DEFS_SVH
`define ANGMR_DEFS_SVH

// ****************************************
// Register offsets
// ****************************************
`define ANGMR_OFS_EXP      5'h06
`define ANGMR_OFS_NPTX     5'h07
`define ANGMR_OFS_NPRX     5'h08
`define ANGMR_OFS_GCTL     5'h09
`define ANGMR_OFS_GSTS     5'h0A
`define ANGMR_OFS_IAC      5'h0D
`define ANGMR_OFS_IAD      5'h0E

// ****************************************
// Field positions
// ****************************************
`define ANGMR_EXP_PDF      4
`define ANGMR_EXP_LPNP     3
`define ANGMR_EXP_LNP      2
`define ANGMR_EXP_PGRX     1
`define ANGMR_EXP_LPAN     0
`define ANGMR_NP_NEXT      15
`define ANGMR_NP_ACK       14
`define ANGMR_NP_MSG       13
`define ANGMR_NP_ACK2      12
`define ANGMR_NP_TOG       11
`define ANGMR_GC_MSEN      12
`define ANGMR_GC_MSVAL     11
`define ANGMR_GS_MSF       15
`define ANGMR_GS_MSR       14
`define ANGMR_GS_LRX       13
`define ANGMR_GS_RRX       12
`define ANGMR_GS_LPFD      11
`define ANGMR_GS_LPHD      10

// ****************************************
// Reset values
// ****************************************
`define ANGMR_RST_NPTX     16'h2001
`define ANGMR_RST_GCTL     16'h0700
`define ANGMR_RST_IAC      16'h0000
`define ANGMR_RST_IAD      16'h0000
`define ANGMR_TEST_LAST    3'h4

`endif

// *** hw/angmr_pkg.sv ***
// Purpose: Types for the gigabit management register group
// Assumes: Nothing beyond the defs header
// Notes:   Function-code enumeration and the negotiation status carrier
`default_nettype none
package angmr_pkg;
   // Indirect access function field
   typedef enum logic [1:0] {
      ANGMR_FN_ADDR   = 2'h0,
      ANGMR_FN_DATA   = 2'h1,
      ANGMR_FN_INC_RW = 2'h2,
      ANGMR_FN_INC_WR = 2'h3
   } angmr_fn_t;

   // Status reported by the negotiation engine
   typedef struct packed {
      logic        pd_fault;
      logic        lp_np_able;
      logic        lp_an_able;
      logic        page_rx;
      logic        ms_fault;
      logic        ms_master;
      logic        local_rx_ok;
      logic        remote_rx_ok;
      logic        lp_gig_fd;
      logic        lp_gig_hd;
      logic        idle_err;
      logic        tx_toggle;
   } angmr_an_sts_t;
endpackage : angmr_pkg
`default_nettype wire

// *** bench/angmr_far_end.sv ***
// Purpose: Far-side model: negotiation status and a small clause-45 register space
// Assumes: Event requests come from the bench one cycle ahead of the pulse
// Notes:   Sixteen-word space, pointer wraps on four bits
`default_nettype none
module angmr_far_end (
   input  wire logic                 clk_sys,
   input  wire logic                 resetn,
   input  wire logic [3:0]           ev_req,
   input  wire logic [7:0]           lv,
   output var  angmr_pkg::angmr_an_sts_t an_sts,
   input  wire logic                 mmd_addr_wr,
   input  wire logic                 mmd_data_wr,
   input  wire logic                 mmd_data_rd,
   input  wire logic                 mmd_post_inc,
   input  wire logic [15:0]          mmd_wdata,
   output logic      [15:0]          mmd_rdata
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [3:0]  ev_reg;
   logic [15:0] ptr_reg;
   logic [15:0] mem [16];
   // Each event bit follows its request one cycle later and repeats while requested
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) ev_reg <= 4'h0;
      else ev_reg <= ev_req;
   end
   assign an_sts = '{pd_fault: ev_reg[3], page_rx: ev_reg[2], ms_fault: ev_reg[1], idle_err: ev_reg[0],
                     lp_np_able: lv[7], lp_an_able: lv[6], ms_master: lv[5], local_rx_ok: lv[4],
                     remote_rx_ok: lv[3], lp_gig_fd: lv[2], lp_gig_hd: lv[1], tx_toggle: lv[0]};
   // Address phase loads the pointer, data phases access it and may step it
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         ptr_reg <= 16'h0000;
         for (int i = 0; i < 16; i++)
            mem[i] <= 16'h5A00 | 16'(i);
      end else begin
         if (mmd_addr_wr) ptr_reg <= mmd_wdata;
         if (mmd_data_wr) mem[ptr_reg[3:0]] <= mmd_wdata;
         if ((mmd_data_wr || mmd_data_rd) && mmd_post_inc) ptr_reg <= ptr_reg + 16'h0001;
      end
   end
   assign mmd_rdata = mem[ptr_reg[3:0]];
endmodule : angmr_far_end
`default_nettype wire

// *** bench/tb.sv ***
// Purpose: Self-checking bench for the gigabit management register group
// Assumes: Read data stands only in the cycle after the read strobe
// Notes:   Far-side model supplies status and the indirect register space
`default_nettype none
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk_sys = 1'b0;
   logic        resetn = 1'b0;
   logic [4:0]  reg_addr = 5'h00;
   logic [15:0] reg_wdata = 16'h0000;
   logic        reg_wr = 1'b0;
   logic        reg_rd = 1'b0;
   logic [15:0] lp_np_word = 16'h0000;
   logic [3:0]  ev_req = 4'h0;
   logic [7:0]  lv = 8'h20;
   logic [3:0]  cap;
   logic [15:0] reg_rdata, np_tx_word, mmd_wdata, mmd_rdata;
   logic [2:0]  test_mode;
   logic [4:0]  target_device_address;
   logic        test_mode_valid, ms_manual, ms_force_master, port_multi, adv_gig_fd, adv_gig_hd;
   logic        mmd_addr_wr, mmd_data_wr, mmd_data_rd, mmd_post_inc;
   angmr_pkg::angmr_an_sts_t an_sts;
   int          err_count = 0;
   int          compares = 0;
   int          cycles = 0;
   wire logic [4:0] ctl = {ms_manual, ms_force_master, port_multi, adv_gig_fd, adv_gig_hd};
   wire logic [3:0] mmd = {mmd_addr_wr, mmd_data_wr, mmd_data_rd, mmd_post_inc};

   angmr_regs angmr_regs_i (.clk_sys, .resetn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
      .an_sts, .lp_np_word, .np_tx_word, .test_mode, .test_mode_valid, .ms_manual, .ms_force_master,
      .port_multi, .adv_gig_fd, .adv_gig_hd, .target_device_address, .mmd_addr_wr, .mmd_data_wr,
      .mmd_data_rd, .mmd_post_inc, .mmd_wdata, .mmd_rdata);
   angmr_far_end angmr_far_end_i (.clk_sys, .resetn, .ev_req, .lv, .an_sts, .mmd_addr_wr,
      .mmd_data_wr, .mmd_data_rd, .mmd_post_inc, .mmd_wdata, .mmd_rdata);

   // Clock and hang guard
   always #2 clk_sys = ~clk_sys;
   always @(posedge clk_sys) begin
      cycles++;
      if (cycles == 5000) begin
         err_count++;
         conclude();
      end
   end

   // ****************************************
   // Access tasks
   // ****************************************
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      compares++;
      if (seen !== exp) begin
         err_count++;
         $display("[FAIL] t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic wr(input logic [4:0] a, input logic [15:0] d);
      @(posedge clk_sys);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      #1 cap = mmd;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
      #1;
   endtask : wr
   task automatic rd(input logic [4:0] a, input logic [15:0] exp);
      @(posedge clk_sys);
      reg_rd <= 1'b1;
      reg_addr <= a;
      #1 cap = mmd;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      #1 chk(reg_rdata, exp);
   endtask : rd
   task automatic conclude();
      $display("compares %0d err_count %0d", compares, err_count);
      if (err_count == 0 && compares > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : conclude

   initial begin
      repeat (16) @(posedge clk_sys);
      resetn <= 1'b1;
      // Reset values, unmapped read
      rd(5'h06, 16'h0004);
      rd(5'h07, 16'h2801);
      rd(5'h08, 16'h0800);
      rd(5'h09, 16'h0700);
      chk(16'(ctl), 16'h0007);
      rd(5'h0A, 16'h4000);
      rd(5'h0D, 16'h0000);
      rd(5'h1F, 16'h0000);
      $display("test reset done");
      // Writable and fixed bits of the transmit page, read-only registers
      lv <= 8'h21;
      wr(5'h07, 16'hFFFF);
      rd(5'h07, 16'hB7FF);
      chk(np_tx_word, 16'hB7FF);
      wr(5'h07, 16'h0000);
      rd(5'h07, 16'h0000);
      wr(5'h06, 16'hFFFF);
      wr(5'h08, 16'hFFFF);
      wr(5'h0A, 16'hFFFF);
      rd(5'h06, 16'h0004);
      rd(5'h08, 16'h0800);
      rd(5'h0A, 16'h4000);
      lv <= 8'hFF;
      lp_np_word <= 16'h5ABC;
      rd(5'h06, 16'h000D);
      rd(5'h08, 16'h52BC);
      rd(5'h0A, 16'h7C00);
      lv <= 8'h00;
      rd(5'h0A, 16'h0000);
      $display("test pages done");
      // Test modes, then master/slave selection
      for (int m = 0; m < 8; m++) begin
         wr(5'h09, {3'(m), 13'h0000});
         chk(16'({test_mode, test_mode_valid}), 16'({3'(m), m < 5}));
      end
      rd(5'h09, 16'hE000);
      wr(5'h09, 16'h0800);
      chk(16'(ctl), 16'h0000);
      wr(5'h09, 16'h1800);
      chk(16'(ctl), 16'h0018);
      wr(5'h09, 16'h1000);
      chk(16'(ctl), 16'h0010);
      $display("test control done");
      // Latched events hold until read; idle count clears and saturates
      ev_req <= 4'hE;
      @(posedge clk_sys);
      ev_req <= 4'h0;
      repeat (2) @(posedge clk_sys);
      rd(5'h06, 16'h0016);
      rd(5'h06, 16'h0004);
      rd(5'h0A, 16'h8000);
      rd(5'h0A, 16'h0000);
      ev_req <= 4'h1;
      repeat (3) @(posedge clk_sys);
      ev_req <= 4'h0;
      rd(5'h0A, 16'h0003);
      rd(5'h0A, 16'h0000);
      ev_req <= 4'h1;
      repeat (300) @(posedge clk_sys);
      ev_req <= 4'h0;
      rd(5'h0A, 16'h00FF);
      rd(5'h0A, 16'h0000);
      $display("test latches done");
      // Indirect access through every function code
      wr(5'h0D, 16'h001F);
      chk(16'(target_device_address), 16'h001F);
      wr(5'h0E, 16'h0003);
      chk(16'(cap), 16'h0008);
      rd(5'h0E, 16'h0003);
      wr(5'h0D, 16'h401F);
      wr(5'h0E, 16'hA5A5);
      chk(16'(cap), 16'h0004);
      rd(5'h0E, 16'hA5A5);
      chk(16'(cap), 16'h0002);
      wr(5'h0D, 16'h801F);
      wr(5'h0E, 16'h1111);
      chk(16'(cap), 16'h0005);
      rd(5'h0E, 16'h5A04);
      chk(16'(cap), 16'h0003);
      wr(5'h0D, 16'hC01F);
      wr(5'h0E, 16'h2222);
      chk(16'(cap), 16'h0005);
      rd(5'h0E, 16'h5A06);
      chk(16'(cap), 16'h0002);
      rd(5'h0E, 16'h5A06);
      rd(5'h0D, 16'hC01F);
      $display("test indirect done");
      conclude();
   end
endmodule : tb
`default_nettype wire
